// >>> rtl/prescaled_down_counter_timer.v
// prescaled 8-bit down-counter timer with apb register slave
// Function
// RULE1: 8-bit counter decremented by one tap of a 7-bit prescaler.
// RULE2: software loads counter; it then counts down per selected tap pulse.
// RULE3: counter reaching zero sets underflow request, control bit 7.
// RULE4: mask bit 6 blocks interrupt when one, passes request when zero.
// RULE5: cpu takes vector when request set, mask clear and cpu enabled.
// RULE6: interrupt is a level; clearing request drops it.
// RULE7: service software checks both shared-vector request bits.
// RULE8: counter wraps zero to all ones; reads never disturb it.
// RULE9: external source advances chain on rising pin edges.
// RULE10: eight taps divide by 1 to 128; tap zero bypasses.
// RULE11: writing bit 3 as one clears prescaler; bit 3 reads zero.
// RULE12: reset sets prescaler and counter to ones, clears request, sets mask.
// RULE13: bits 0,1,2,4,5 load from option byte; writable only in software mode.
// RULE14: software mode: all bits read/write except bit 3, write-only.
// RULE15: fixed mode: bits 7,6 read/write; others ignore writes, read one.
// RULE16: fixed mode bit 3 depends on variant: clear-strobe or reads one.
// RULE17: option bit 6 zero selects software mode, one fixed mode.
// RULE18: bits 4,5 pick source; both zero gives internal clock.
// RULE19: pin enable alone gates internal clock with pin level.
// RULE20: source select alone stops the prescaler input.
// RULE21: both one drives prescaler from external pin.
// RULE22: fixed mode takes divide and source from option bits 0,1,2,5.
// RULE23: software clears prescaler when changing divide select.
// RULE24: count pin is synchronised and edge-detected before use.
// RULE25: counter read value is stable for the whole read cycle.
`timescale 1ns/100ps
`include "timer_consts.vh"
module prescaled_down_counter_timer #(
  parameter CNT_W = 8,
  parameter PRE_W = 7
) (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // non-volatile option byte, stable from power-up
  input  wire [7:0]  option_byte_register,
  // count / gate pin
  input  wire        count_pin,
  // cpu side
  input  wire        second_ext_irq,
  output reg         timer_irq,
  output reg         vector_irq
);
  localparam S_IDLE   = `STATE_IDLE;
  localparam S_SETUP  = `STATE_SETUP;
  localparam S_ACCESS = `STATE_ACCESS;

  reg [2:0]       state_reg;
  reg [2:0]       state_next;
  reg [CNT_W-1:0] count_reg;
  reg [PRE_W-1:0] prescale_reg;
  reg [PRE_W-1:0] prescale_next;
  reg             underflow_request_reg;
  reg             underflow_mask_reg;
  reg             source_select_reg;
  reg             pin_enable_reg;
  reg [2:0]       divide_select_reg;
  reg [7:0]       opt_reg;
  reg             opt_loaded_reg;

  wire pin_level;
  wire pin_rise;

  // RULE24
  pin_edge_sync u_pin_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_in    (count_pin),
    .pin_level (pin_level),
    .pin_rise  (pin_rise)
  );

  wire fixed_mode   = opt_reg[`BIT_OPT];           // RULE17
  wire variant_r5   = opt_reg[`BIT_R5VAR];
  // pready is high only in the access cycle, so it marks the committing edge
  wire access_now   = psel & penable & pready;
  wire wr_now       = access_now & pwrite;
  wire [`ADDR_MSB:`ADDR_LSB] word = paddr[`ADDR_MSB:`ADDR_LSB];
  wire hit_ctrl     = (word == `ADDR_CTRL   >> `ADDR_LSB);
  wire hit_count    = (word == `ADDR_COUNT  >> `ADDR_LSB);
  wire hit_option   = (word == `ADDR_OPTION >> `ADDR_LSB);
  wire hit_status   = (word == `ADDR_STATUS >> `ADDR_LSB);
  wire aligned      = (paddr[1:0] == 2'b00);
  wire mapped       = aligned & (hit_ctrl | hit_count | hit_option | hit_status);
  wire wr_ctrl      = wr_now & aligned & hit_ctrl;
  wire wr_count     = wr_now & aligned & hit_count;

  // fixed mode takes source and division straight from the option byte
  wire       eff_src = fixed_mode ? opt_reg[`BIT_SRC] : source_select_reg;  // RULE22
  wire       eff_pin = fixed_mode ? 1'b1 : pin_enable_reg;
  wire [2:0] eff_div = fixed_mode ? opt_reg[`DIV_MSB:`DIV_LSB] : divide_select_reg;

  // prescaler input; internal phase-two clock is every pclk edge
  reg prescaler_in;
  always @* begin
    case ({eff_src, eff_pin})
      2'b00:   prescaler_in = 1'b1;       // RULE18
      2'b01:   prescaler_in = pin_level;  // RULE19
      2'b10:   prescaler_in = 1'b0;       // RULE20
      default: prescaler_in = pin_rise;   // RULE9 RULE21
    endcase
    // no count until the option byte has set the source, so reset values hold
    if (!opt_loaded_reg)
      prescaler_in = 1'b0;                // RULE12
  end

  // clear strobe honoured unless fixed mode on the variant that ignores it
  wire clear_allowed = ~fixed_mode | ~variant_r5;                          // RULE16
  wire prescale_clr  = wr_ctrl & pwdata[`BIT_CLR] & clear_allowed;        // RULE11

  // tap k pulses when prescaler bit k-1 falls; tap 0 is the input itself
  always @* begin
    prescale_next = prescale_reg;
    if (prescaler_in)
      prescale_next = prescale_reg + `PRESCALE_ONE;
  end
  // tap k ticks on the edge where prescaler bit k-1 goes from one to zero
  wire tap_fall   = prescaler_in & prescale_reg[eff_div - 3'd1] & ~prescale_next[eff_div - 3'd1]; // RULE10
  wire count_tick = (eff_div == `DIV_ONE) ? prescaler_in : tap_fall;                                // RULE1

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prescale_reg <= `PRESCALE_RESET;    // RULE12
    else if (prescale_clr)
      prescale_reg <= `PRESCALE_CLEAR;
    else
      prescale_reg <= prescale_next;
  end

  // counter: load wins over a decrement in the same cycle
  wire [CNT_W-1:0] count_dec = count_reg - `COUNT_ONE;
  wire             hit_zero  = count_tick & (count_reg == `COUNT_ONE);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      count_reg <= `COUNT_RESET;          // RULE12
    else if (wr_count)
      count_reg <= pwdata[CNT_W-1:0];     // RULE2
    else if (count_tick)
      count_reg <= count_dec;             // RULE2 RULE8
  end

  // option byte is caught once after reset release
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_reg        <= 8'h00;
      opt_loaded_reg <= 1'b0;
    end else if (!opt_loaded_reg) begin
      opt_reg        <= option_byte_register;
      opt_loaded_reg <= 1'b1;
    end
  end

  // control register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      underflow_request_reg <= 1'b0;      // RULE12
      underflow_mask_reg    <= 1'b1;      // RULE12
      source_select_reg     <= 1'b0;
      pin_enable_reg        <= 1'b0;
      divide_select_reg     <= `DIV_ONE;
    end else begin
      if (!opt_loaded_reg) begin
        source_select_reg <= option_byte_register[`BIT_SRC];   // RULE13
        pin_enable_reg    <= option_byte_register[`BIT_PIN];
        divide_select_reg <= option_byte_register[`DIV_MSB:`DIV_LSB];
      end else if (wr_ctrl && !fixed_mode) begin
        source_select_reg <= pwdata[`BIT_SRC];                 // RULE13 RULE14
        pin_enable_reg    <= pwdata[`BIT_PIN];
        divide_select_reg <= pwdata[`DIV_MSB:`DIV_LSB];
      end
      if (wr_ctrl)
        underflow_mask_reg <= pwdata[`BIT_MASK];               // RULE4 RULE15
      // underflow in the same cycle as a software clear wins
      if (hit_zero)
        underflow_request_reg <= 1'b1;                         // RULE3
      else if (wr_ctrl)
        underflow_request_reg <= pwdata[`BIT_REQ];             // RULE6
    end
  end

  // control read image
  reg [7:0] ctrl_image;
  always @* begin
    if (fixed_mode)
      ctrl_image = `FIXED_ONES | {6'h00, 1'b0, 1'b0} | {4'h0, variant_r5, 3'h0};  // RULE15 RULE16
    else
      ctrl_image = {2'b00, source_select_reg, pin_enable_reg, 1'b0, divide_select_reg}; // RULE14 RULE11
    ctrl_image[`BIT_REQ]  = underflow_request_reg;
    ctrl_image[`BIT_MASK] = underflow_mask_reg;
  end

  // apb state machine, zero wait states
  always @* begin
    case (state_reg)
      S_IDLE:   state_next = (psel && !penable) ? S_SETUP : S_IDLE;
      S_SETUP:  state_next = S_ACCESS;
      S_ACCESS: state_next = (psel && !penable) ? S_SETUP : S_IDLE;
      default:  state_next = S_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      state_reg <= S_IDLE;
    else
      state_reg <= state_next;
  end

  // registered apb outputs: pready high in the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= `DATA_ZERO;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= (state_next == S_SETUP);
      pslverr <= (state_next == S_SETUP) & ~mapped;
      prdata  <= `DATA_ZERO;
      if (state_next == S_SETUP) begin
        if (hit_ctrl && aligned)
          prdata <= {24'h000000, ctrl_image};
        else if (hit_count && aligned)
          prdata <= {{(32-CNT_W){1'b0}}, count_reg};  // RULE25 RULE8: snapshot held through access
        else if (hit_option && aligned)
          prdata <= {24'h000000, opt_reg};
        else if (hit_status && aligned)
          prdata <= {30'h00000000, second_ext_irq, underflow_request_reg};
      end
    end
  end

  // level interrupt to the core; vector line merges the shared source
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_irq  <= 1'b0;
      vector_irq <= 1'b0;
    end else begin
      timer_irq  <= underflow_request_reg & ~underflow_mask_reg;                    // RULE4 RULE5 RULE6
      vector_irq <= (underflow_request_reg & ~underflow_mask_reg) | second_ext_irq; // RULE7
    end
  end
endmodule // prescaled_down_counter_timer

// >>> rtl/timer_consts.vh
// constants for the prescaled down-counter timer
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH
`define ADDR_CTRL        12'h000
`define ADDR_COUNT       12'h004
`define ADDR_OPTION      12'h008
`define ADDR_STATUS      12'h00C
`define ADDR_LSB         2
`define ADDR_MSB         11
`define BIT_REQ          7
`define BIT_MASK         6
`define BIT_SRC          5
`define BIT_PIN          4
`define BIT_CLR          3
`define BIT_OPT          6
`define BIT_R5VAR        7
`define DIV_LSB          0
`define DIV_MSB          2
`define COUNT_RESET      8'hFF
`define PRESCALE_RESET   7'h7F
`define PRESCALE_CLEAR   7'h00
`define PRESCALE_ONE     7'h01
`define COUNT_ONE        8'h01
`define COUNT_ZERO       8'h00
`define DIV_ONE          3'h0
`define FIXED_ONES       8'h37
`define DATA_ZERO        32'h00000000
`define STATE_IDLE       3'h1
`define STATE_SETUP      3'h2
`define STATE_ACCESS     3'h4
`endif

// >>> rtl/pin_edge_sync.v
// two-stage synchroniser with rising-edge pulse for the count pin
`timescale 1ns/100ps
module pin_edge_sync (
  // clock and reset
  input  wire pclk,
  input  wire presetn,
  // pin and results
  input  wire pin_in,
  output reg  pin_level,
  output reg  pin_rise
);
  reg meta_reg;
  reg last_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg  <= 1'b0;
      pin_level <= 1'b0;
      last_reg  <= 1'b0;
      pin_rise  <= 1'b0;
    end else begin
      meta_reg  <= pin_in;
      pin_level <= meta_reg;
      last_reg  <= pin_level;
      pin_rise  <= pin_level & ~last_reg;
    end
  end
endmodule // pin_edge_sync

// >>> test/timer_monitor.sv
// port-level assertion checker for the prescaled down-counter timer
`timescale 1ns/100ps
module timer_monitor (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // option byte and interrupts
  input wire logic [7:0]  option_byte_register,
  input wire logic        second_ext_irq,
  input wire logic        timer_irq,
  input wire logic        vector_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_ctrl = pready && !pwrite && paddr == 12'h000;
  a_zero_wait: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  a_ready_access: assert property (pready |-> psel && penable) else $error("ready outside access");
  a_ready_single: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  a_idle_data: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
  a_bad_addr: assert property (pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr > 12'h00C))
    else $error("error response wrong");
  a_upper_zero: assert property (pready && !pslverr |-> prdata[31:8] == 24'h0) else $error("upper bits set");
  a_clear_reads: assert property (rd_ctrl && !option_byte_register[6] |-> !prdata[3])
    else $error("clear bit read as one");
  a_fixed_ones: assert property (rd_ctrl && option_byte_register[6] |->
    prdata[5:0] == {2'h3, option_byte_register[7], 3'h7}) else $error("fixed bits wrong");
  a_irq_masking: assert property (rd_ctrl |-> timer_irq == (prdata[7] && !prdata[6]))
    else $error("timer irq disagrees with request and mask");
  a_vector_or: assert property (vector_irq == (timer_irq || $past(second_ext_irq)))
    else $error("vector irq wrong");
endmodule // timer_monitor

bind prescaled_down_counter_timer timer_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .option_byte_register(option_byte_register), .second_ext_irq(second_ext_irq), .timer_irq(timer_irq),
  .vector_irq(vector_irq));

// >>> test/pin_partner.sv
// far-side model: count pin and second interrupt source
`timescale 1ns/100ps
module pin_partner (
  // clock
  input  wire pclk,
  // driven lines
  output reg  count_pin,
  output reg  second_ext_irq
);
  initial begin
    count_pin = 1'b0;
    second_ext_irq = 1'b0;
  end
  // pin high for exactly n cycles, so a gated clock passes n counts
  task gate(input int n);
    @(posedge pclk) count_pin <= 1'b1;
    repeat (n) @(posedge pclk);
    count_pin <= 1'b0;
  endtask
  // pin high for p cycles, then low for p+1; shorter than one would slip through the synchroniser
  task edges(input int n, input int p);
    repeat (n) begin
      @(posedge pclk) count_pin <= 1'b1;
      repeat (p) @(posedge pclk);
      count_pin <= 1'b0;
      repeat (p) @(posedge pclk);
    end
  endtask
  task irq2(input logic l);
    @(posedge pclk) second_ext_irq <= l;
  endtask
endmodule // pin_partner

// >>> test/tb_top.sv
// self-checking bench for the prescaled down-counter timer
`timescale 1ns/100ps
module tb_top;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, timer_irq, vector_irq, count_pin, second_ext_irq;
  logic [7:0]  opt = 8'h25, v;
  logic [32:0] expq[$], e;
  int          mismatches = 0, total_checks = 0, cycles = 0, i;
  always #12.5 pclk = ~pclk;
  prescaled_down_counter_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .option_byte_register(opt), .count_pin(count_pin), .second_ext_irq(second_ext_irq),
    .timer_irq(timer_irq), .vector_irq(vector_irq));
  pin_partner u_pin (.pclk(pclk), .count_pin(count_pin), .second_ext_irq(second_ext_irq));
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task cmp(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task chk_irq(input logic [1:0] x);
    repeat (3) @(posedge pclk);
    cmp({31'h0, timer_irq, vector_irq}, {31'h0, x});
  endtask
  // request held until pready is seen high; the global timeout ends a hang
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x);
    expq.push_back(x);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, {1'b0, x});
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task rst(input logic [7:0] o);
    presetn <= 1'b0;
    opt <= o;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask
  // write results carry only the error flag
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 20000) begin
      mismatches++;
      report_and_stop;
    end
    if (psel && penable && pready) begin
      e = expq.pop_front();
      cmp({pslverr, pwrite ? 32'h0 : prdata}, e);
    end
  end
  initial begin
    v = $urandom(32'h802195d0);
    v = $urandom;
    rst(8'h25);
    rd(12'h000, 32'h65);
    rd(12'h004, 32'hFF);
    rd(12'h008, 32'h25);
    apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 12'h002, 32'h0, {1'b1, 32'h0});
    wr(12'h004, {24'h0, v});
    wr(12'h000, 32'hFF);
    rd(12'h000, 32'hF7);
    wr(12'h000, 32'h68);
    u_pin.edges(3, 2);
    rd(12'h004, {24'h0, v});
    rd(12'h004, {24'h0, v});
    for (i = 0; i < 8; i++) begin
      wr(12'h004, 32'h80);
      wr(12'h000, {29'h0B, i[2:0]});
      u_pin.gate(2 << i);
      repeat (6) @(posedge pclk);
      rd(12'h004, 32'h7E);
    end
    wr(12'h000, 32'h78);
    u_pin.edges(5, 3);
    repeat (6) @(posedge pclk);
    rd(12'h004, 32'h79);
    wr(12'h004, 32'h02);
    wr(12'h000, 32'h18);
    chk_irq(2'b00);
    u_pin.gate(3);
    repeat (6) @(posedge pclk);
    rd(12'h004, 32'hFF);
    rd(12'h00C, 32'h1);
    chk_irq(2'b11);
    wr(12'h000, 32'hD0);
    rd(12'h000, 32'hD0);
    chk_irq(2'b00);
    wr(12'h000, 32'h50);
    chk_irq(2'b00);
    rd(12'h00C, 32'h0);
    u_pin.irq2(1'b1);
    chk_irq(2'b01);
    rd(12'h00C, 32'h2);
    u_pin.irq2(1'b0);
    wr(12'h004, 32'h03);
    wr(12'h000, 32'h08);
    repeat (10) @(posedge pclk);
    rd(12'h00C, 32'h1);
    chk_irq(2'b11);
    rst(8'hC0);
    rd(12'h000, 32'h7F);
    wr(12'h000, 32'h00);
    rd(12'h000, 32'h3F);
    report_and_stop;
  end
endmodule // tb_top
